// ==== src/sff_device.sv ====
// FIFO device: memory, pointers, flags, offsets and chain pulses
`timescale 1ns/1ps
`include "sff_cfg.svh"
module sff_device
    import sff_pkg::*;
#(
    parameter int         DEPTH        = `SFF_DEPTH,
    parameter logic [7:0] MODE_MAP     = `SFF_MODE_MAP,
    parameter bit         DEPTH_EXPAND = 1'b0
) (
    input  wire logic mclk_i,
    input  wire logic rst_i,
    sff_link_if.dev   link,
    output logic      fall_through_mode_o
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = AW + 1;
    localparam int DW = `SFF_DATA_W;
    localparam int OW = `SFF_OFF_W;
    localparam logic [OW-1:0] OFF_DEF = (DEPTH == 256) ? `SFF_OFF_DEF_256 :
        (DEPTH == 512) ? `SFF_OFF_DEF_512 : `SFF_OFF_DEF_BIG;

    logic [DW-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic [OW-1:0] ae_off_q;
    logic [OW-1:0] af_off_q;
    sff_sel_e      ld_sel_q;
    sff_sel_e      rd_sel_q;
    logic [DW-1:0] out_q;
    logic          out_vld_q;
    logic [1:0]    ready_pipe_q;
    logic          fall_through_mode_q;
    logic          strap_done_q;
    logic          wtok_q;
    logic          rtok_q;
    logic          full_n_q;
    logic          empty_n_q;
    logic          ae_n_q;
    logic          af_n_q;
    logic          wxo_n_q;
    logic          rxo_n_q;
    logic          oe_q;

    wire clr        = rst_i | ~link.reset_n;
    wire wr_req     = ~link.write_en_n;
    wire rd_req     = ~link.read_en_n;
    wire ld         = ~link.offset_load_n;
    wire [2:0] strap = {link.first_load_n, link.write_chain_in_n,
                        link.read_chain_in_n};
    wire mode_fall_through_mode  = MODE_MAP[strap];
    wire mem_full   = cnt_q == CW'(DEPTH);
    wire mem_empty  = cnt_q == '0;
    wire wtok_ok    = !DEPTH_EXPAND || wtok_q;
    wire rtok_ok    = !DEPTH_EXPAND || rtok_q;
    wire do_wr      = wr_req & ~ld & ~mem_full & wtok_ok;
    wire out_take   = fall_through_mode_q & out_vld_q & rd_req & ~ld;
    wire fall_load  = fall_through_mode_q & ready_pipe_q[1] & ~mem_empty &
                      (~out_vld_q | out_take);
    wire std_rd     = ~fall_through_mode_q & rd_req & ~ld & ~mem_empty & rtok_ok;
    wire do_pop     = std_rd | fall_load;
    wire last_wr    = do_wr & (wr_ptr_q == AW'(DEPTH - 1));
    wire last_rd    = do_pop & (rd_ptr_q == AW'(DEPTH - 1));
    wire out_vld_d  = fall_load | (out_vld_q & ~out_take);
    wire [CW-1:0] total = cnt_d + CW'(fall_through_mode_q ? out_vld_d : 1'b0);
    wire [CW-1:0] space = CW'(DEPTH) - total;
    wire [OW-1:0] off_rd = (rd_sel_q == SFF_SEL_EMPTY) ? ae_off_q : af_off_q;
    // Offsets and totals compared at a width that holds both
    localparam int XW = OW + CW;
    wire [XW-1:0] tot_x = XW'(total);
    wire [XW-1:0] spc_x = XW'(space);
    wire [XW-1:0] ae_x  = XW'(ae_off_q);
    wire [XW-1:0] af_x  = XW'(af_off_q);

    always_comb
    begin
        cnt_d = cnt_q;
        if (do_wr && !do_pop)
        begin
            cnt_d = cnt_q + CW'(1);
        end
        else if (!do_wr && do_pop)
        begin
            cnt_d = cnt_q - CW'(1);
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (do_wr)
        begin
            mem[wr_ptr_q] <= link.write_data;
        end
    end

    // Strap capture after reset release
    always_ff @(posedge mclk_i)
    begin
        if (clr)
        begin
            strap_done_q <= 1'b0;
            fall_through_mode_q       <= 1'b0;
        end
        else if (!strap_done_q)
        begin
            strap_done_q <= 1'b1;
            fall_through_mode_q       <= mode_fall_through_mode;
        end
    end

    // Pointers and count
    always_ff @(posedge mclk_i)
    begin
        if (clr)
        begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            cnt_q    <= '0;
        end
        else
        begin
            cnt_q <= cnt_d;
            if (do_wr)
            begin
                wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0
                                                         : wr_ptr_q + AW'(1);
            end
            if (do_pop)
            begin
                rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0
                                                         : rd_ptr_q + AW'(1);
            end
        end
    end

    // Offset registers, loaded alternately empty then full
    always_ff @(posedge mclk_i)
    begin
        if (clr)
        begin
            ae_off_q <= OFF_DEF;
            af_off_q <= OFF_DEF;
            ld_sel_q <= SFF_SEL_EMPTY;
        end
        else if (ld && wr_req)
        begin
            unique case (ld_sel_q)
                SFF_SEL_EMPTY: ae_off_q <= link.write_data[OW-1:0];
                SFF_SEL_FULL:  af_off_q <= link.write_data[OW-1:0];
            endcase
            ld_sel_q <= (ld_sel_q == SFF_SEL_EMPTY) ? SFF_SEL_FULL
                                                    : SFF_SEL_EMPTY;
        end
    end

    // Output register
    always_ff @(posedge mclk_i)
    begin
        if (clr)
        begin
            out_q     <= '0;
            out_vld_q <= 1'b0;
            rd_sel_q  <= SFF_SEL_EMPTY;
        end
        else
        begin
            out_vld_q <= out_vld_d;
            if (ld && rd_req)
            begin
                out_q    <= {{(DW-OW){1'b0}}, off_rd};
                rd_sel_q <= (rd_sel_q == SFF_SEL_EMPTY) ? SFF_SEL_FULL
                                                        : SFF_SEL_EMPTY;
            end
            else if (do_pop)
            begin
                out_q <= mem[rd_ptr_q];
            end
        end
    end

    // Fall-through readiness delay
    always_ff @(posedge mclk_i)
    begin
        if (clr)
        begin
            ready_pipe_q <= '0;
        end
        else
        begin
            ready_pipe_q <= {ready_pipe_q[0], ~mem_empty};
        end
    end

    // Expansion tokens
    always_ff @(posedge mclk_i)
    begin
        if (clr)
        begin
            wtok_q <= 1'b0;
            rtok_q <= 1'b0;
        end
        else if (!strap_done_q)
        begin
            wtok_q <= ~link.first_load_n;
            rtok_q <= ~link.first_load_n;
        end
        else
        begin
            if (last_wr)
            begin
                wtok_q <= 1'b0;
            end
            else if (!link.write_chain_in_n)
            begin
                wtok_q <= 1'b1;
            end
            if (last_rd)
            begin
                rtok_q <= 1'b0;
            end
            else if (!link.read_chain_in_n)
            begin
                rtok_q <= 1'b1;
            end
        end
    end

    // Registered flags
    always_ff @(posedge mclk_i)
    begin
        if (clr)
        begin
            full_n_q  <= 1'b1;
            empty_n_q <= 1'b0;
            ae_n_q    <= 1'b0;
            af_n_q    <= 1'b1;
            wxo_n_q   <= 1'b1;
            rxo_n_q   <= 1'b1;
            oe_q      <= 1'b0;
        end
        else
        begin
            full_n_q  <= cnt_d != CW'(DEPTH);
            empty_n_q <= fall_through_mode_q ? out_vld_d : (cnt_d != '0);
            ae_n_q    <= tot_x > ae_x;
            af_n_q    <= spc_x > af_x;
            wxo_n_q   <= DEPTH_EXPAND ? ~last_wr
                                      : (total <= CW'(DEPTH / 2));
            rxo_n_q   <= ~(DEPTH_EXPAND & last_rd);
            oe_q      <= ~link.output_enable_n;
        end
    end

    assign link.read_data           = out_q;
    assign link.read_data_oe        = oe_q;
    assign link.full_flag_n         = full_n_q;
    assign link.empty_flag_n        = empty_n_q;
    assign link.almost_empty_flag_n = ae_n_q;
    assign link.almost_full_flag_n  = af_n_q;
    assign link.write_chain_out_n   = wxo_n_q;
    assign link.read_chain_out_n    = rxo_n_q;
    assign fall_through_mode_o      = fall_through_mode_q;
endmodule

// ==== shared/sff_cfg.svh ====
// Constants of the synchronous FIFO and its driving end
// Function
// - Read bus driven only while output enable low
// - Load low plus write stores offset registers
// - Load low plus read presents offset registers
// - Strap levels select timing and flag mode
// - First device first_load low, later ones high
// - Write chain in fed from previous output
// - Read chain in fed from previous output
// - Standard mode: shared output is full flag
// - Fall-through mode: shared output is input ready
// - Standard mode: shared output is empty flag
// - Fall-through mode: output ready shows valid word
// - Almost-empty low within programmed offset
// - Almost-empty offset reset default per depth
// - Almost-full low within programmed offset; in fall-through mode it goes high again at DEPTH+1 words
// - Almost-full offset reset default per depth
// - Single device: half-full low above half
// - Expansion: pulse write chain on last write
// - Expansion: pulse read chain on last read
// - Reset clears pointers and sets flag levels
// - Writes ignored while full
// - Reads ignored while empty, output held
// - Fall-through first word shows after three edges
`ifndef SFF_CFG_SVH
`define SFF_CFG_SVH
`define SFF_DATA_W        18
`define SFF_OFF_W         12
`define SFF_DEPTH         256
`define SFF_OFF_DEF_256   12'h01f
`define SFF_OFF_DEF_512   12'h03f
`define SFF_OFF_DEF_BIG   12'h07f
`define SFF_FALL_EDGES    3
`define SFF_MODE_MAP      8'h0f
`define SFF_BUF_DEPTH     4
`endif

// ==== shared/sff_pkg.sv ====
// Types shared by both ends of the FIFO link
package sff_pkg;
    typedef enum logic {SFF_SEL_EMPTY, SFF_SEL_FULL} sff_sel_e;
endpackage

// ==== shared/sff_link_if.sv ====
// Pin-level link between the FIFO device and its driving logic
`timescale 1ns/1ps
`include "sff_cfg.svh"
interface sff_link_if;
    logic [`SFF_DATA_W-1:0] write_data;
    logic [`SFF_DATA_W-1:0] read_data;
    logic                   read_data_oe;
    logic                   write_en_n;
    logic                   read_en_n;
    logic                   offset_load_n;
    logic                   output_enable_n;
    logic                   first_load_n;
    logic                   write_chain_in_n;
    logic                   read_chain_in_n;
    logic                   reset_n;
    logic                   full_flag_n;
    logic                   empty_flag_n;
    logic                   almost_empty_flag_n;
    logic                   almost_full_flag_n;
    logic                   write_chain_out_n;
    logic                   read_chain_out_n;
    modport dev (
        input  write_data, write_en_n, read_en_n, offset_load_n,
               output_enable_n, first_load_n, write_chain_in_n,
               read_chain_in_n, reset_n,
        output read_data, read_data_oe, full_flag_n, empty_flag_n,
               almost_empty_flag_n, almost_full_flag_n,
               write_chain_out_n, read_chain_out_n
    );
    modport host (
        output write_data, write_en_n, read_en_n, offset_load_n,
               output_enable_n, first_load_n, write_chain_in_n,
               read_chain_in_n, reset_n,
        input  read_data, read_data_oe, full_flag_n, empty_flag_n,
               almost_empty_flag_n, almost_full_flag_n,
               write_chain_out_n, read_chain_out_n
    );
endinterface

// ==== src/sff_host.sv ====
// Driving end of the FIFO link with its write buffer
`timescale 1ns/1ps
`include "sff_cfg.svh"
module sff_buf
    import sff_pkg::*;
#(
    parameter int WIDTH = `SFF_DATA_W,
    parameter int DEPTH = `SFF_BUF_DEPTH
) (
    input  wire logic             mclk_i,
    input  wire logic             rst_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    output logic      [WIDTH-1:0] out_data_o,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wp_q;
    logic [AW-1:0]    rp_q;
    logic [AW:0]      cnt_q;
    wire push = in_valid_i & in_ready_o;
    wire pop  = out_valid_o & out_ready_i;
    assign in_ready_o  = cnt_q != (AW+1)'(DEPTH);
    assign out_valid_o = cnt_q != '0;
    assign out_data_o  = mem[rp_q];

    always_ff @(posedge mclk_i)
    begin
        if (push)
        begin
            mem[wp_q] <= in_data_i;
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end
        else
        begin
            wp_q  <= push ? wp_q + AW'(1) : wp_q;
            rp_q  <= pop ? rp_q + AW'(1) : rp_q;
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

module sff_host
    import sff_pkg::*;
#(
    parameter logic [2:0] STRAP = 3'b111
) (
    input  wire logic                   mclk_i,
    input  wire logic                   rst_i,
    sff_link_if.host                    link,
    input  wire logic [`SFF_DATA_W-1:0] wr_data_i,
    input  wire logic                   wr_valid_i,
    output logic                        wr_ready_o,
    input  wire logic                   ld_i,
    input  wire logic                   rd_req_i,
    input  wire logic                   oe_i,
    output logic [`SFF_DATA_W-1:0]      rd_data_o,
    output logic                        rd_valid_o
);
    logic [`SFF_DATA_W-1:0] bdata;
    logic                   bvalid;
    logic                   bready;
    logic [`SFF_DATA_W-1:0] wd_q;
    logic                   wen_q;
    logic                   ren_q;
    logic                   rvld_q;
    logic [`SFF_DATA_W-1:0] rd_q;
    logic                   rv_q;
    logic                   ld_q;
    logic                   oe_q;
    logic                   rst_q;

    // Pop only while the device shows room and no write is in flight
    assign bready = link.full_flag_n & ~wen_q;

    sff_buf #(.WIDTH(`SFF_DATA_W), .DEPTH(`SFF_BUF_DEPTH)) i_sff_buf (
        .mclk_i      (mclk_i),
        .rst_i       (rst_i),
        .in_data_i   (wr_data_i),
        .in_valid_i  (wr_valid_i),
        .in_ready_o  (wr_ready_o),
        .out_data_o  (bdata),
        .out_valid_o (bvalid),
        .out_ready_i (bready)
    );

    wire rd_go = rd_req_i & link.empty_flag_n & ~ren_q;

    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            wd_q   <= '0;
            wen_q  <= 1'b0;
            ren_q  <= 1'b0;
            rvld_q <= 1'b0;
            rd_q   <= '0;
            rv_q   <= 1'b0;
            ld_q   <= 1'b0;
            oe_q   <= 1'b0;
            rst_q  <= 1'b1;
        end
        else
        begin
            rst_q  <= 1'b0;
            wen_q  <= bvalid & bready;
            wd_q   <= bdata;
            ld_q   <= ld_i;
            oe_q   <= oe_i;
            ren_q  <= rd_go;
            rvld_q <= ren_q;
            rv_q   <= rvld_q;
            rd_q   <= link.read_data;
        end
    end

    assign link.write_data       = wd_q;
    assign link.write_en_n       = ~wen_q;
    assign link.read_en_n        = ~ren_q;
    assign link.offset_load_n    = ~ld_q;
    assign link.output_enable_n  = ~oe_q;
    assign link.reset_n          = ~rst_q;
    assign link.first_load_n     = STRAP[2];
    assign link.write_chain_in_n = STRAP[1];
    assign link.read_chain_in_n  = STRAP[0];
    assign rd_data_o             = rd_q;
    assign rd_valid_o            = rv_q;
endmodule

// ==== verification/sff_assertions.sv ====
// Concurrent checks on the signals of the FIFO link
`timescale 1ns/1ps
`include "sff_cfg.svh"
module sff_assertions (
    input wire logic                   mclk_i,
    input wire logic                   rst_i,
    input wire logic [`SFF_DATA_W-1:0] read_data,
    input wire logic                   read_data_oe,
    input wire logic                   write_en_n,
    input wire logic                   read_en_n,
    input wire logic                   offset_load_n,
    input wire logic                   output_enable_n,
    input wire logic                   full_flag_n,
    input wire logic                   empty_flag_n,
    input wire logic                   almost_empty_flag_n,
    input wire logic                   almost_full_flag_n,
    input wire logic                   write_chain_out_n,
    input wire logic                   read_chain_out_n
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    property p_reset;
        disable iff (1'b0)
        rst_i |=> full_flag_n && almost_full_flag_n && !empty_flag_n &&
                  !almost_empty_flag_n && write_chain_out_n && read_chain_out_n;
    endproperty
    a_reset: assert property (p_reset)
        else $error("flags not at reset levels");

    property p_oe_on;
        $fell(output_enable_n) |=> read_data_oe;
    endproperty
    a_oe_on: assert property (p_oe_on)
        else $error("read bus not driven after enable");

    property p_oe_off;
        output_enable_n |=> !read_data_oe;
    endproperty
    a_oe_off: assert property (p_oe_off)
        else $error("read bus driven while disabled");

    property p_full_hold;
        !full_flag_n && read_en_n |=> !full_flag_n;
    endproperty
    a_full_hold: assert property (p_full_hold)
        else $error("full left without a read");

    property p_empty_hold;
        !empty_flag_n && write_en_n && (read_en_n || offset_load_n)
            |=> $stable(read_data) && !empty_flag_n;
    endproperty
    a_empty_hold: assert property (p_empty_hold)
        else $error("output changed while empty");

    property p_empty_rise;
        !empty_flag_n && !write_en_n && offset_load_n && full_flag_n
            |=> empty_flag_n;
    endproperty
    a_empty_rise: assert property (p_empty_rise)
        else $error("empty flag kept after a write");

    property p_af;
        !full_flag_n |-> !almost_full_flag_n;
    endproperty
    a_af: assert property (p_af)
        else $error("almost-full high while full");

    property p_ae;
        !empty_flag_n |-> !almost_empty_flag_n;
    endproperty
    a_ae: assert property (p_ae)
        else $error("almost-empty high while empty");

    property p_hf;
        !full_flag_n |-> !write_chain_out_n;
    endproperty
    a_hf: assert property (p_hf)
        else $error("half-full high while full");

    property p_rxo;
        read_chain_out_n;
    endproperty
    a_rxo: assert property (p_rxo)
        else $error("read chain pulse in single mode");
endmodule

// ==== verification/tb.sv ====
// Self-checking bench joining the FIFO device and its driving end
`timescale 1ns/1ps
`include "sff_cfg.svh"
module tb;
    import sff_pkg::*;
    localparam int DEPTH = `SFF_DEPTH;
    logic                   mclk_i     = 1'b0;
    logic                   rst_i      = 1'b1;
    logic [`SFF_DATA_W-1:0] wr_data_i  = '0;
    logic                   wr_valid_i = 1'b0;
    logic                   ld_i       = 1'b0;
    logic                   rd_req_i   = 1'b0;
    logic                   oe_i       = 1'b0;
    logic                   wr_ready_o;
    logic [`SFF_DATA_W-1:0] rd_data_o;
    logic                   rd_valid_o;
    logic                   fall_through_mode_o;
    int                     mismatches  = 0;
    int                     checks_done = 0;
    int                     cycles, words, nr_ow, nr_or, nr_rd;
    logic [11:0]            ae_off, af_off;
    bit                     sel_w, sel_r;
    logic [`SFF_DATA_W-1:0] mem_q[$];
    logic [`SFF_DATA_W-1:0] exp_q[$];

    sff_link_if link_if ();
    sff_device i_sff_device (.mclk_i(mclk_i), .rst_i(rst_i), .link(link_if),
        .fall_through_mode_o(fall_through_mode_o));
    sff_host i_sff_host (.mclk_i(mclk_i), .rst_i(rst_i), .link(link_if),
        .wr_data_i(wr_data_i), .wr_valid_i(wr_valid_i),
        .wr_ready_o(wr_ready_o), .ld_i(ld_i), .rd_req_i(rd_req_i),
        .oe_i(oe_i), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o));
    sff_assertions i_sff_assertions (.mclk_i(mclk_i), .rst_i(rst_i),
        .read_data(link_if.read_data), .read_data_oe(link_if.read_data_oe),
        .write_en_n(link_if.write_en_n), .read_en_n(link_if.read_en_n),
        .offset_load_n(link_if.offset_load_n),
        .output_enable_n(link_if.output_enable_n),
        .full_flag_n(link_if.full_flag_n),
        .empty_flag_n(link_if.empty_flag_n),
        .almost_empty_flag_n(link_if.almost_empty_flag_n),
        .almost_full_flag_n(link_if.almost_full_flag_n),
        .write_chain_out_n(link_if.write_chain_out_n),
        .read_chain_out_n(link_if.read_chain_out_n));

    always #5 mclk_i = ~mclk_i;

    task automatic print_verdict();
        if (mismatches == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic cmp_bit(input logic got, input logic exp);
        checks_done++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic cmp_word(input logic [17:0] got, input logic [17:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Streams n words into the write buffer
    task automatic send(input int n, input logic [17:0] first);
        wr_valid_i = 1'b1;
        for (int i = 0; i < n; i++)
        begin
            wr_data_i = first + 18'(i);
            @(posedge mclk_i);
            while (wr_ready_o !== 1'b1)
                @(posedge mclk_i);
            #1;
        end
        wr_valid_i = 1'b0;
    endtask

    always @(posedge mclk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            print_verdict();
        end
    end

    // Reference model of contents and offsets
    always @(posedge mclk_i)
    begin
        if (rst_i || link_if.reset_n !== 1'b1)
        begin
            ae_off = `SFF_OFF_DEF_256;
            af_off = `SFF_OFF_DEF_256;
            sel_w = 1'b0;
            sel_r = 1'b0;
            mem_q.delete();
        end
        else
        begin
            if (!link_if.read_en_n && !link_if.offset_load_n)
            begin
                exp_q.push_back({6'h00, sel_r ? af_off : ae_off});
                sel_r = !sel_r;
                nr_or++;
            end
            else if (!link_if.read_en_n && link_if.empty_flag_n)
            begin
                exp_q.push_back(mem_q.pop_front());
                nr_rd++;
            end
            if (!link_if.write_en_n && !link_if.offset_load_n)
            begin
                if (sel_w)
                    af_off = link_if.write_data[11:0];
                else
                    ae_off = link_if.write_data[11:0];
                sel_w = !sel_w;
                nr_ow++;
            end
            else if (!link_if.write_en_n && link_if.full_flag_n)
                mem_q.push_back(link_if.write_data);
        end
    end

    // Flag levels against the model
    always @(negedge mclk_i)
        if (!rst_i && link_if.reset_n === 1'b1)
        begin
            words = mem_q.size();
            cmp_bit(link_if.full_flag_n, words != DEPTH);
            cmp_bit(link_if.empty_flag_n, words != 0);
            cmp_bit(link_if.almost_empty_flag_n, words > int'(ae_off));
            cmp_bit(link_if.almost_full_flag_n,
                    (DEPTH - words) > int'(af_off));
            cmp_bit(link_if.write_chain_out_n, words <= DEPTH / 2);
        end

    always @(posedge mclk_i)
        if (rd_valid_o === 1'b1)
            cmp_word(rd_data_o, exp_q.pop_front());

    initial
    begin
        repeat (4) @(posedge mclk_i);
        #1 rst_i = 1'b0;
        repeat (3) @(posedge mclk_i);
        #1;
        cmp_bit(fall_through_mode_o, 1'b0);
        oe_i = 1'b1;
        repeat (3) @(posedge mclk_i);
        #1;
        cmp_bit(link_if.read_data_oe, 1'b1);
        oe_i = 1'b0;
        ld_i = 1'b1;
        send(2, 18'h00020);
        while (nr_ow < 2)
        begin
            @(posedge mclk_i);
            #1;
        end
        ld_i = 1'b0;
        send(DEPTH + 3, 18'h3f000);
        repeat (20) @(posedge mclk_i);
        #1;
        cmp_bit(link_if.full_flag_n, 1'b0);
        ld_i = 1'b1;
        rd_req_i = 1'b1;
        while (nr_or < 2)
        begin
            @(posedge mclk_i);
            #1;
        end
        rd_req_i = 1'b0;
        repeat (2) @(posedge mclk_i);
        #1 ld_i = 1'b0;
        rd_req_i = 1'b1;
        while (nr_rd < DEPTH + 3)
            @(posedge mclk_i);
        repeat (10) @(posedge mclk_i);
        #1 rd_req_i = 1'b0;
        cmp_bit(exp_q.size() == 0, 1'b1);
        print_verdict();
    end
endmodule
